// [inc/hac_regs.svh]
// register offsets, command codes and timing counts of the humidity alarm
// assumes a 25 MHz system clock; the long write count is overridable
`ifndef HAC_REGS_SVH
`define HAC_REGS_SVH
`define HAC_CLK_KHZ 25000
`define HAC_NVM_READ_NS 600
`define HAC_NVM_WRITE_SETUP_US 200
`define HAC_NVM_WRITE_US 6800
`define HAC_OP_READ_RESULT 8'h40
`define HAC_OP_WRITE_CONFIG 8'hC0
`define HAC_OP_WRITE_NVM 8'hE0
`define HAC_OP_READ_NVM 8'h60
`define HAC_OP_ERASE_NVM 8'hE2
`define HAC_OP_RESTART 8'h88
`define HAC_CFG_RUN 7'h4D
`define HAC_CFG_NVM_POWER 7'h1C
`define HAC_RUN_SET 8'h01
`define HAC_RUN_CLEAR 8'h00
`define HAC_NVM_POWER_UP 8'hC4
`define HAC_NVM_POWER_DOWN 8'h44
`define HAC_RES_TEMP_HI 7'h00
`define HAC_RES_TEMP_LO 7'h01
`define HAC_RES_TEMP_SUM 7'h02
`define HAC_RES_HUM_HI 7'h03
`define HAC_RES_HUM_LO 7'h04
`define HAC_RES_HUM_SUM 7'h05
`define HAC_STATUS_BYTE 7'h18
`define HAC_STATUS_RUN_BIT 0
`define HAC_STATUS_BUSY_BIT 3
`define HAC_UPPER_TRIP_ON_LEVEL 7'h54
`define HAC_UPPER_TRIP_OFF_LEVEL 7'h56
`define HAC_LOWER_TRIP_OFF_LEVEL 7'h58
`define HAC_LOWER_TRIP_ON_LEVEL 7'h5A
`define HAC_TRIP_RESET 16'h0000
`define HAC_RUN_RESET 1'b1
`endif

// [inc/hac_pkg.sv]
// types shared by the humidity alarm configuration block
// assumes hac_regs.svh is included by the design file
package hac_pkg;
  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_ADDR     = 7'b0000010,
    ST_ACK_ADDR = 7'b0000100,
    ST_WR_BYTE  = 7'b0001000,
    ST_ACK_WR   = 7'b0010000,
    ST_RD_BYTE  = 7'b0100000,
    ST_RD_ACK   = 7'b1000000
  } hac_state_type;

  typedef struct packed {
    logic signed [15:0] upper_on;
    logic signed [15:0] upper_off;
    logic signed [15:0] lower_off;
    logic signed [15:0] lower_on;
  } hac_trip_type;

  typedef struct packed {
    logic [15:0] value;
    logic valid;
  } hac_result_type;
endpackage

// [rtl/hac_config.sv]
// i2c command slave, run-enable, nvm timing, status byte and humidity alarms
// assumes scl/sda come from pins and results arrive on clk_sys with a strobe
//
// Overview of operation
// - nvm byte read data is ready 600 ns after the read starts.
// - nvm byte write lasts 6.8 ms; no new write meanwhile.
// - run-enable gates the front-end; shown in status bit 0.
// - C0 4D 01 sets run-enable, C0 4D 00 clears it.
// - C0 1C C4 powers the nvm up, C0 1C 44 powers it down.
// - status byte sits at result location 24.
// - status bit 3 is nvm busy; bits 2:1 and 7:4 reserved.
// - four signed 8-fraction trip values, upper byte first from 54h, zero.
// - alarms compare humidity only, never temperature.
// - in analog output mode only the upper alarm works.
// - upper alarm on at upper on-trip, off at upper off-trip.
// - lower alarm on at lower on-trip, off at lower off-trip.
// - hysteresis is the gap between each alarm's on and off trips.
`timescale 1ns/1ps
`include "hac_regs.svh"

module hac_config import hac_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = 7'h28,
  parameter int NVM_WRITE_CYC = `HAC_NVM_WRITE_US * (`HAC_CLK_KHZ / 1000)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // i2c pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // measurement path
  input wire logic [15:0] temp_value,
  input wire logic temp_valid,
  input wire logic [15:0] hum_value,
  input wire logic hum_valid,
  input wire logic analog_mode,
  output logic frontend_enable,
  output logic nvm_power_on,
  output logic restart_pulse,
  // alarm pins
  output logic alarm_upper,
  output logic alarm_lower
);
  localparam int NVM_READ_CYC = (`HAC_NVM_READ_NS * `HAC_CLK_KHZ) / 1000000;

  // ==========================================================
  // pin synchronisers and line filter
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_f;
  logic sda_f;
  logic scl_p;
  logic sda_p;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      // a level counts only once the later two stages agree
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign bus_start = scl_f & scl_p & sda_p & ~sda_f;
  assign bus_stop = scl_f & scl_p & ~sda_p & sda_f;

  // ==========================================================
  // i2c byte engine
  hac_state_type state;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] tx_data;
  logic [3:0] bit_cnt;
  logic read_dir;

  logic wr_byte_done;
  logic rd_ack_ok;
  assign wr_byte_done = scl_fall && state == ST_WR_BYTE && bit_cnt == 4'h8;
  assign rd_ack_ok = scl_rise && state == ST_RD_ACK && !sda_f;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      bit_cnt <= 4'h0;
      read_dir <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      if (scl_rise && (state == ST_ADDR || state == ST_WR_BYTE)) begin
        rx_shift <= {rx_shift[6:0], sda_f};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (bit_cnt == 4'h8) begin
              if (rx_shift[7:1] == SLAVE_ADDR) begin
                state <= ST_ACK_ADDR;
                read_dir <= rx_shift[0];
                sda_oe <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK_ADDR: begin
            bit_cnt <= 4'h0;
            if (read_dir) begin
              state <= ST_RD_BYTE;
              tx_shift <= {tx_data[6:0], 1'b0};
              sda_oe <= ~tx_data[7];
              bit_cnt <= 4'h1;
            end else begin
              state <= ST_WR_BYTE;
              sda_oe <= 1'b0;
            end
          end
          ST_WR_BYTE: begin
            if (bit_cnt == 4'h8) begin
              state <= ST_ACK_WR;
              sda_oe <= 1'b1;
            end
          end
          ST_ACK_WR: begin
            state <= ST_WR_BYTE;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
          end
          ST_RD_BYTE: begin
            if (bit_cnt == 4'h8) begin
              state <= ST_RD_ACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~tx_shift[7];
              tx_shift <= {tx_shift[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_RD_ACK: begin
            // a nack from the host ends the read
            if (!sda_p) begin
              state <= ST_RD_BYTE;
              tx_shift <= {tx_data[6:0], 1'b0};
              sda_oe <= ~tx_data[7];
              bit_cnt <= 4'h1;
            end else begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // command decode, pointer, run-enable, nvm storage
  logic [7:0] opcode;
  logic [1:0] byte_idx;
  logic [6:0] ptr;
  logic run_enable;
  logic [7:0] trip_mem [0:7];
  logic nvm_busy_flag;
  logic [17:0] busy_cnt;
  logic fetch_go;
  logic trip_hit;
  logic [2:0] trip_idx;

  assign trip_hit = ptr >= `HAC_UPPER_TRIP_ON_LEVEL &&
                    ptr <= `HAC_LOWER_TRIP_ON_LEVEL + 7'h1;
  assign trip_idx = 3'(ptr - `HAC_UPPER_TRIP_ON_LEVEL);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opcode <= 8'h00;
      byte_idx <= 2'h0;
      ptr <= 7'h00;
      run_enable <= `HAC_RUN_RESET;
      nvm_power_on <= 1'b0;
      restart_pulse <= 1'b0;
      fetch_go <= 1'b0;
      nvm_busy_flag <= 1'b0;
      busy_cnt <= 18'h00000;
      for (int i = 0; i < 8; i++) begin
        trip_mem[i] <= 8'h00;
      end
    end else begin
      restart_pulse <= 1'b0;
      fetch_go <= 1'b0;
      if (bus_start) begin
        byte_idx <= 2'h0;
      end
      if (nvm_busy_flag) begin
        if (busy_cnt == 18'(NVM_WRITE_CYC - 1)) begin
          nvm_busy_flag <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt + 18'h1;
        end
      end
      if (rd_ack_ok) begin
        ptr <= ptr + 7'h1;
        fetch_go <= 1'b1;
      end
      if (wr_byte_done) begin
        if (byte_idx != 2'h3) begin
          byte_idx <= byte_idx + 2'h1;
        end
        if (byte_idx == 2'h0) begin
          opcode <= rx_shift;
          if (rx_shift == `HAC_OP_RESTART) begin
            restart_pulse <= 1'b1;
            run_enable <= 1'b1;
          end
        end else if (byte_idx == 2'h1) begin
          ptr <= rx_shift[6:0];
          fetch_go <= 1'b1;
        end else begin
          ptr <= ptr + 7'h1;
          if (opcode == `HAC_OP_WRITE_CONFIG) begin
            if (ptr == `HAC_CFG_RUN && rx_shift == `HAC_RUN_SET) begin
              run_enable <= 1'b1;
            end
            if (ptr == `HAC_CFG_RUN && rx_shift == `HAC_RUN_CLEAR) begin
              run_enable <= 1'b0;
            end
            if (ptr == `HAC_CFG_NVM_POWER &&
                rx_shift == `HAC_NVM_POWER_UP) begin
              nvm_power_on <= 1'b1;
            end
            if (ptr == `HAC_CFG_NVM_POWER &&
                rx_shift == `HAC_NVM_POWER_DOWN) begin
              nvm_power_on <= 1'b0;
            end
            if (trip_hit) begin
              trip_mem[trip_idx] <= rx_shift;
            end
          end else if ((opcode == `HAC_OP_WRITE_NVM ||
                        opcode == `HAC_OP_ERASE_NVM) && !nvm_busy_flag) begin
            nvm_busy_flag <= 1'b1;
            busy_cnt <= 18'h00000;
            if (trip_hit) begin
              // nvm cells only gain ones; erase clears them
              if (opcode == `HAC_OP_WRITE_NVM) begin
                trip_mem[trip_idx] <= trip_mem[trip_idx] | rx_shift;
              end else begin
                trip_mem[trip_idx] <= 8'h00;
              end
            end
          end
        end
      end
    end
  end

  assign frontend_enable = run_enable;

  // ==========================================================
  // results and read fetch
  logic [15:0] temp_res;
  logic [15:0] hum_res;
  logic [4:0] fetch_cnt;
  logic [7:0] result_byte;
  logic [7:0] status_byte;

  // busy in bit 3, reserved bits zero
  assign status_byte = {4'h0, nvm_busy_flag, 2'h0, run_enable};

  always_comb begin
    case (ptr)
      `HAC_RES_TEMP_HI: result_byte = temp_res[15:8];
      `HAC_RES_TEMP_LO: result_byte = temp_res[7:0];
      `HAC_RES_TEMP_SUM: result_byte = temp_res[15:8] + temp_res[7:0];
      `HAC_RES_HUM_HI: result_byte = hum_res[15:8];
      `HAC_RES_HUM_LO: result_byte = hum_res[7:0];
      `HAC_RES_HUM_SUM: result_byte = hum_res[15:8] + hum_res[7:0];
      `HAC_STATUS_BYTE: result_byte = status_byte;
      default: result_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      temp_res <= 16'h0000;
      hum_res <= 16'h0000;
      tx_data <= 8'h00;
      fetch_cnt <= 5'h00;
    end else begin
      if (temp_valid) begin
        temp_res <= temp_value;
      end
      if (hum_valid) begin
        hum_res <= hum_value;
      end
      if (fetch_go && opcode == `HAC_OP_READ_RESULT) begin
        tx_data <= result_byte;
      end else if (fetch_go && opcode == `HAC_OP_READ_NVM) begin
        fetch_cnt <= 5'(NVM_READ_CYC);
      end else if (fetch_cnt != 5'h00) begin
        fetch_cnt <= fetch_cnt - 5'h1;
        // nvm byte appears after the read time
        if (fetch_cnt == 5'h01) begin
          tx_data <= trip_hit ? trip_mem[trip_idx] : 8'h00;
        end
      end
    end
  end

  // ==========================================================
  // humidity alarms
  hac_trip_type trip;
  // upper byte at the lower location
  assign trip.upper_on = {trip_mem[0], trip_mem[1]};
  assign trip.upper_off = {trip_mem[2], trip_mem[3]};
  assign trip.lower_off = {trip_mem[4], trip_mem[5]};
  assign trip.lower_on = {trip_mem[6], trip_mem[7]};

  logic signed [15:0] hum_s;
  assign hum_s = hum_value;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alarm_upper <= 1'b0;
      alarm_lower <= 1'b0;
    end else if (restart_pulse) begin
      alarm_upper <= 1'b0;
      alarm_lower <= 1'b0;
    end else if (hum_valid) begin
      // humidity only, signed inclusive per result
      // upper on at on-trip, off at off-trip
      // hysteresis falls out of the two trips
      if (!alarm_upper && hum_s >= trip.upper_on) begin
        alarm_upper <= 1'b1;
      end else if (alarm_upper && hum_s <= trip.upper_off) begin
        alarm_upper <= 1'b0;
      end
      // analog mode silences the lower alarm
      if (analog_mode) begin
        alarm_lower <= 1'b0;
      // lower on at on-trip, off at off-trip
      end else if (!alarm_lower && hum_s <= trip.lower_on) begin
        alarm_lower <= 1'b1;
      end else if (alarm_lower && hum_s >= trip.lower_off) begin
        alarm_lower <= 1'b0;
      end
    end else if (analog_mode) begin
      alarm_lower <= 1'b0;
    end
  end
endmodule

// [bench/hac_config_chk.sv]
// port checker for the humidity alarm block
// assumes a bind onto hac_config; one clock domain
`timescale 1ns/1ps
module hac_config_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // watched ports
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic temp_valid,
  input wire logic hum_valid,
  input wire logic analog_mode,
  input wire logic frontend_enable,
  input wire logic nvm_power_on,
  input wire logic restart_pulse,
  input wire logic alarm_upper,
  input wire logic alarm_lower
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // =====
  // sequences
  sequence s_analog_held;
    analog_mode ##1 analog_mode;
  endsequence
  // every run-enable change and nvm power-up comes with an acked byte
  sequence s_acked;
    ##[0:40] sda_oe;
  endsequence
  // =====
  // assertions
  a_open_drain: assert property (
    sda_oe |-> !sda_out) else $error("sda driven high");
  a_up_rise: assert property (
    $rose(alarm_upper) |-> $past(hum_valid)) else $error("upper rose");
  a_up_fall: assert property (
    $fell(alarm_upper) |-> $past(hum_valid) || $past(restart_pulse)
    || restart_pulse) else $error("upper fell");
  a_lo_rise: assert property (
    $rose(alarm_lower) |-> $past(hum_valid) && !$past(analog_mode))
    else $error("lower rose");
  a_analog_low: assert property (
    s_analog_held |-> !alarm_lower) else $error("lower in analog");
  a_temp_only: assert property (
    temp_valid && !hum_valid && !restart_pulse && !analog_mode |=>
    $stable(alarm_upper) && $stable(alarm_lower)) else $error("temp");
  a_restart_clr: assert property (
    restart_pulse && !hum_valid |=> frontend_enable && !alarm_upper
    && !alarm_lower) else $error("restart");
  a_run_ack: assert property (
    $changed(frontend_enable) |-> s_acked) else $error("run change");
  a_nvm_ack: assert property (
    $rose(nvm_power_on) |-> s_acked) else $error("nvm power");
endmodule

bind hac_config hac_config_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .sda_out(sda_out), .sda_oe(sda_oe), .temp_valid(temp_valid),
  .hum_valid(hum_valid), .analog_mode(analog_mode),
  .frontend_enable(frontend_enable), .nvm_power_on(nvm_power_on),
  .restart_pulse(restart_pulse), .alarm_upper(alarm_upper),
  .alarm_lower(alarm_lower));

// [bench/hac_i2c_host.sv]
// i2c host model, 320 ns per bit
// assumes the bench resolves sda with a pull-up
`timescale 1ns/1ps
module hac_i2c_host (
  // pins
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  int nack_cnt = 0;
  // scl stands high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // =====
  // bit level
  // sda moves halfway through the low phase, clear of the pin filter lag
  // long low phase: the device answers about 200 ns after scl falls
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #120 sda_drv = b;
    #120 scl = 1'b1;
    #40 r = sda_line;
    #40;
  endtask
  task automatic start();
    scl = 1'b0;
    #120 sda_drv = 1'b1;
    #120 scl = 1'b1;
    #160 sda_drv = 1'b0;
    #160;
  endtask
  task automatic stop();
    scl = 1'b0;
    #120 sda_drv = 1'b0;
    #120 scl = 1'b1;
    #160 sda_drv = 1'b1;
    #160;
  endtask
  // =====
  // byte level
  task automatic wb(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    if (r !== 1'b0) begin
      nack_cnt++;
    end
  endtask
  task automatic rb(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// [bench/test_humidity_alarm_config.sv]
// self-checking bench for the humidity alarm block
// assumes the host model and the checker are compiled first
`timescale 1ns/1ps
module test_humidity_alarm_config;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic temp_valid = 1'b0;
  logic hum_valid = 1'b0;
  logic analog_mode = 1'b0;
  logic [15:0] temp_value = 16'h0000;
  logic [15:0] hum_value = 16'h0000;
  logic scl, sda_drv, sda_oe, sda_out, sda_line;
  logic frontend_enable, nvm_power_on, restart_pulse;
  logic alarm_upper, alarm_lower;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int rst_seen = 0;
  // open-drain wire with pull-up
  assign sda_line = sda_drv & (~sda_oe | sda_out);
  always #20 clk_sys = ~clk_sys;
  // short write time keeps the run brief
  hac_config #(.NVM_WRITE_CYC(2000)) i_dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .temp_value(temp_value), .temp_valid(temp_valid),
    .hum_value(hum_value), .hum_valid(hum_valid),
    .analog_mode(analog_mode), .frontend_enable(frontend_enable),
    .nvm_power_on(nvm_power_on), .restart_pulse(restart_pulse),
    .alarm_upper(alarm_upper), .alarm_lower(alarm_lower));
  hac_i2c_host i_host (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  always @(posedge clk_sys) begin
    cyc++;
    if (restart_pulse === 1'b1) begin
      rst_seen++;
    end
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end
  // =====
  // helpers
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] q[$], input logic stp);
    i_host.start();
    i_host.wb(8'h50);
    foreach (q[i]) begin
      i_host.wb(q[i]);
    end
    if (stp) begin
      i_host.stop();
      repeat (2) @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic rd_byte(input string what, input logic [7:0] op, adr,
    exp);
    logic [7:0] d;
    send('{op, adr}, 1'b0);
    i_host.start();
    i_host.wb(8'h51);
    i_host.rb(1'b1, d);
    i_host.stop();
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask
  task automatic rd_status(input logic [7:0] exp);
    rd_byte("status", 8'h40, 8'h18, exp);
  endtask
  task automatic hum(input logic [15:0] v, input logic up, lo);
    @(posedge clk_sys);
    hum_value <= v;
    hum_valid <= 1'b1;
    @(posedge clk_sys);
    hum_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("alarm_upper", {15'h0, up}, {15'h0, alarm_upper});
    chk("alarm_lower", {15'h0, lo}, {15'h0, alarm_lower});
  endtask
  // =====
  // scenarios
  task automatic t_reset();
    @(posedge clk_sys);
    temp_value <= 16'h7F00;
    temp_valid <= 1'b1;
    @(posedge clk_sys);
    temp_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("run", 16'h0001, {15'h0, frontend_enable});
    chk("alarms", 16'h0000, {14'h0, alarm_upper, alarm_lower});
    hum(16'h0000, 1'b1, 1'b1);
  endtask
  task automatic t_nvm();
    send('{8'hC0, 8'h4D, 8'h00}, 1'b1);
    chk("run", 16'h0000, {15'h0, frontend_enable});
    rd_status(8'h00);
    send('{8'hC0, 8'h1C, 8'hC4}, 1'b1);
    chk("nvm_power", 16'h0001, {15'h0, nvm_power_on});
    repeat (5000) @(posedge clk_sys);
    #1;
    send('{8'hE2, 8'h55, 8'h00}, 1'b1);
    rd_status(8'h08);
    repeat (2100) @(posedge clk_sys);
    repeat (5000) @(posedge clk_sys);
    #1;
    send('{8'hE0, 8'h55, 8'h80}, 1'b1);
    rd_status(8'h08);
    repeat (2100) @(posedge clk_sys);
    #1;
    rd_byte("nvm_read", 8'h60, 8'h55, 8'h80);
    rd_status(8'h00);
    send('{8'hC0, 8'h1C, 8'h44}, 1'b1);
    chk("nvm_power", 16'h0000, {15'h0, nvm_power_on});
    send('{8'hC0, 8'h4D, 8'h01}, 1'b1);
    rd_status(8'h01);
    send('{8'h88}, 1'b1);
    chk("restart", 16'h0001, rst_seen[15:0]);
    chk("alarms", 16'h0000, {14'h0, alarm_upper, alarm_lower});
    hum(16'h007F, 1'b0, 1'b0);
    hum(16'h0080, 1'b1, 1'b0);
  endtask
  task automatic t_alarm();
    logic [15:0] hv[9] = '{16'h4FFF, 16'h5000, 16'h4601, 16'h4600,
      16'h1E01, 16'h1E00, 16'h27FF, 16'h2800, 16'hF000};
    logic [1:0] ex[9] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b00, 2'b01,
      2'b01, 2'b00, 2'b01};
    send('{8'hC0, 8'h4D, 8'h00}, 1'b1);
    send('{8'hC0, 8'h54, 8'h50, 8'h00, 8'h46, 8'h00, 8'h28, 8'h00,
      8'h1E, 8'h00}, 1'b1);
    send('{8'hC0, 8'h4D, 8'h01}, 1'b1);
    send('{8'h88}, 1'b1);
    foreach (hv[i]) begin
      hum(hv[i], ex[i][1], ex[i][0]);
    end
    @(posedge clk_sys);
    analog_mode <= 1'b1;
    hum(16'hF000, 1'b0, 1'b0);
    hum(16'h6000, 1'b1, 1'b0);
    rd_byte("hum_hi", 8'h40, 8'h03, 8'h60);
    @(posedge clk_sys);
    analog_mode <= 1'b0;
  endtask
  // =====
  // closing
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_nvm();
    t_alarm();
    chk("nack", 16'h0000, i_host.nack_cnt[15:0]);
    complete_run();
  end
endmodule
